// ---- common/fwp_params.svh ----
/*
  timing counts, register offsets, field positions and reset values of
  the function word printer control.
  assumes a 100 MHz sys_clk; included by bare name.
*/
`ifndef FWP_PARAMS_SVH
`define FWP_PARAMS_SVH
// ****************************************
// timing
// ****************************************
`define FWP_CLK_KHZ 100000
`define FWP_LOCKOUT_MS 70
`define FWP_READY_MS 500
// ****************************************
// register map
// ****************************************
`define FWP_ADDR_W 4
`define FWP_OFS_DIV 4'h0
`define FWP_OFS_STAT 4'h4
`define FWP_OFS_FWORD 4'h8
`define FWP_OFS_CHAR 4'hC
`define FWP_DIV_RST 16'h28B0
// ****************************************
// function word fields
// ****************************************
`define FWP_FW_OUT_EN 0
`define FWP_FW_PRN 1
`define FWP_FW_PERF 2
`define FWP_FW_IN_EN 3
`define FWP_IN_NONE 3'h0
`define FWP_IN_KEYB 3'h1
`define FWP_IN_READ 3'h2
`define FWP_IN_RSTART 3'h6
`define FWP_CHAR_W 7
`define FWP_FIFO_D 4
`define FWP_FRAME_LAST 4'h8
`endif

// ---- common/fwp_pkg.sv ----
/*
  types shared by the function word printer control files.
  assumes nothing of its surroundings.
*/
package fwp_pkg;
  // printer output loop states
  typedef enum logic [1:0] {
    FWP_P_OFF  = 2'b00,
    FWP_P_WARM = 2'b01,
    FWP_P_REQ  = 2'b10,
    FWP_P_SEND = 2'b11
  } fwp_pstate_e;
  typedef logic [15:0] fwp_div_t;
endpackage

// ---- verilog/fwp_fifo.sv ----
/*
  small flip-flop fifo with valid/ready on both sides.
  assumes one clock, active-low async reset and a freezing clock enable.
*/
`timescale 1ns/100ps
module fwp_fifo #(
  parameter int W = 7,
  parameter int D = 4
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0]   cnt_r;
  logic          push;
  logic          pop;

  // full and empty come straight from the fill count
  // the count is one bit wider than the pointers, so full is cast to that width
  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign push      = clk_en & in_valid & in_ready;
  assign pop       = clk_en & out_valid & out_ready;
  assign out_data  = mem_r[rp_r];

  // storage: one word per entry
  genvar gi;
  generate
    for (gi = 0; gi < D; gi++) begin : g_ent
      always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
          mem_r[gi] <= '0;
        end else if (push && (wp_r == AW'(gi))) begin
          mem_r[gi] <= in_data;
        end
      end
    end
  endgenerate

  // pointers and count
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ---- verilog/fwp_serializer.sv ----
/*
  character serializer toward the printer: space start, data lsb first,
  mark stop. assumes the same clock and reset as the control block.
*/
`timescale 1ns/100ps
`include "fwp_params.svh"
module fwp_serializer #(
  parameter int W = 7
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         clk_en,
  input  wire logic [15:0]  bit_div,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic              txd,
  output logic              done
);
  logic         busy_r;
  logic [3:0]   idx_r;
  logic [15:0]  tick_r;
  logic [W:0]   sh_r;
  logic         bit_end;

  assign in_ready = ~busy_r;
  // a zero divisor still gives one cycle per element
  assign bit_end  = (tick_r == '0);

  // frame sequencing; line idles at mark
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      idx_r  <= '0;
      tick_r <= '0;
      sh_r   <= '1;
      txd    <= 1'b1;
      done   <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (!busy_r) begin
        if (in_valid) begin
          busy_r <= 1'b1;
          idx_r  <= '0;
          tick_r <= bit_div;
          sh_r   <= {1'b1, in_data};
          txd    <= 1'b0;
        end
      end else if (!bit_end) begin
        tick_r <= tick_r - 1'b1;
      end else if (idx_r == `FWP_FRAME_LAST) begin
        busy_r <= 1'b0;
        done   <= 1'b1;
        txd    <= 1'b1;
      end else begin
        // data bits then the stop bit shift out
        txd    <= sh_r[0];
        sh_r   <= {1'b1, sh_r[W:1]};
        idx_r  <= idx_r + 1'b1;
        tick_r <= bit_div;
      end
    end
  end
endmodule

// ---- verilog/fwp_ctrl.sv ----
/*
  function word printer control: decodes host function words into device
  enables, paces the function handshake with its lockout and runs the
  printer output loop through a fifo and the serializer.
  assumes host pins are asynchronous to sys_clk; registers are reached
  over a plain strobe port on the same clock.
*/
// Strobed register access and the address map were left to the implementer.
// Behaviour
// [RULE_01] output enable clear keeps output enables
// [RULE_02] bits 2..1 select printer and perforator
// [RULE_03] input enable clear keeps input enables
// [RULE_04] bits 6..4 select keyboard, reader, read start
// [RULE_05] request held low 70 ms per word
// [RULE_06] lockout blocks head-up read start clear
// [RULE_07] printer word sets select, lamp, motor
// [RULE_08] half second later ready, clear, request
// [RULE_09] host drives data then output acknowledge
// [RULE_10] acknowledge latches data, drops request, starts serializer
// [RULE_11] frame is start space, bits, stop mark
// [RULE_12] printer gets seven bit code
// [RULE_13] after character clear register, request again
// [RULE_14] host deselects printer with word 001
// [RULE_15] printer clear, master clear, deselect stop printer
// [RULE_16] request up when idle, ack takes word
// [RULE_17] host drops acknowledge after word taken
// [RULE_18] ack pulse stretched into request lockout
// [RULE_19] delays are cycle counters of sys_clk
`timescale 1ns/100ps
`include "fwp_params.svh"
module fwp_ctrl #(
  parameter int LOCKOUT_CYC = `FWP_LOCKOUT_MS * (`FWP_CLK_KHZ), // [RULE_19]
  parameter int READY_CYC   = `FWP_READY_MS * (`FWP_CLK_KHZ)
) (
  input  wire logic                   sys_clk,
  input  wire logic                   nrst,
  input  wire logic                   clk_en,
  input  wire logic                   function_acknowledge,
  input  wire logic                   output_word_acknowledge,
  input  wire logic [7:0]             host_data,
  input  wire logic                   printer_clear,
  input  wire logic                   master_clear,
  input  wire logic                   head_raised,
  output logic                        function_request,
  output logic                        output_word_request,
  output logic                        printer_enable,
  output logic                        printer_lamp,
  output logic                        printer_motor,
  output logic                        perforator_enable,
  output logic                        keyboard_enable,
  output logic                        reader_enable,
  output logic                        read_start,
  output logic                        printer_txd,
  input  wire logic [`FWP_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic [31:0]                 reg_rdata
);
  import fwp_pkg::*;

  localparam int CW = `FWP_CHAR_W;

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [12:0] sy1_r;
  logic [12:0] sy2_r;
  logic        fack_d_r;
  logic        oack_d_r;
  logic        pclr_d_r;
  logic        mclr_d_r;
  logic        fack_s;
  logic        oack_s;
  logic        pclr_s;
  logic        mclr_s;
  logic        head_s;
  logic [7:0]  data_s;

  // two flops on every pin; only the second stage is read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else if (clk_en) begin
      sy1_r <= {function_acknowledge, output_word_acknowledge, printer_clear,
                master_clear, head_raised, host_data};
      sy2_r <= sy1_r;
    end
  end

  assign {fack_s, oack_s, pclr_s, mclr_s, head_s, data_s} = sy2_r;

  // edge history of the synchronised strobes
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fack_d_r <= 1'b0;
      oack_d_r <= 1'b0;
      pclr_d_r <= 1'b0;
      mclr_d_r <= 1'b0;
    end else if (clk_en) begin
      fack_d_r <= fack_s;
      oack_d_r <= oack_s;
      pclr_d_r <= pclr_s;
      mclr_d_r <= mclr_s;
    end
  end

  logic fack_rise;
  logic oack_rise;
  logic pclr_rise;
  logic mclr_rise;
  assign fack_rise = fack_s & ~fack_d_r;
  assign oack_rise = oack_s & ~oack_d_r;
  assign pclr_rise = pclr_s & ~pclr_d_r;
  assign mclr_rise = mclr_s & ~mclr_d_r;

  // ****************************************
  // function handshake and lockout
  // ****************************************
  logic        func_req_r;
  logic [31:0] lock_cnt_r;
  logic        lock_active;
  logic        take;
  logic [6:0]  word;

  assign lock_active      = (lock_cnt_r != '0);
  // a word is taken only while the request stands
  assign take             = clk_en & fack_rise & func_req_r; // [RULE_16]
  assign word             = data_s[6:0];
  assign function_request = func_req_r;

  // the acknowledge edge starts a long lockout; the request returns at its end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      func_req_r <= 1'b1;
      lock_cnt_r <= '0;
    end else if (clk_en) begin
      if (take) begin
        func_req_r <= 1'b0; // [RULE_16]
        lock_cnt_r <= 32'(LOCKOUT_CYC); // [RULE_18]
      end else if (lock_cnt_r == 32'h0000_0001) begin
        lock_cnt_r <= '0;
        func_req_r <= 1'b1; // [RULE_05]
      end else if (lock_active) begin
        lock_cnt_r <= lock_cnt_r - 1'b1;
      end
    end
  end

  // ****************************************
  // device enables
  // ****************************************
  logic [6:0] last_fw_r;

  // output enables; either clear overrides a word's printer select in the same cycle, master clear also its perforator select
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      printer_enable    <= 1'b0;
      perforator_enable <= 1'b0;
    end else if (clk_en) begin
      if (take && word[`FWP_FW_OUT_EN]) begin // [RULE_01]
        printer_enable    <= word[`FWP_FW_PRN]; // [RULE_02] [RULE_07]
        perforator_enable <= word[`FWP_FW_PERF]; // [RULE_02]
      end
      if (pclr_rise || mclr_rise) begin
        printer_enable <= 1'b0; // [RULE_15]
      end
      if (mclr_rise) begin
        perforator_enable <= 1'b0;
      end
    end
  end

  // input enables; unused codes leave them as they were
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      keyboard_enable <= 1'b0;
      reader_enable   <= 1'b0;
    end else if (clk_en) begin
      if (take && word[`FWP_FW_IN_EN]) begin // [RULE_03]
        case (word[6:4]) // [RULE_04]
          `FWP_IN_NONE: begin
            keyboard_enable <= 1'b0;
            reader_enable   <= 1'b0;
          end
          `FWP_IN_KEYB: begin
            keyboard_enable <= 1'b1;
            reader_enable   <= 1'b0;
          end
          `FWP_IN_READ, `FWP_IN_RSTART: begin
            keyboard_enable <= 1'b0;
            reader_enable   <= 1'b1;
          end
          default: begin
            keyboard_enable <= keyboard_enable;
          end
        endcase
      end
      if (mclr_rise) begin
        keyboard_enable <= 1'b0;
        reader_enable   <= 1'b0;
      end
    end
  end

  // read start flag; a new start wins over a head-up clear
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      read_start <= 1'b0;
    end else if (clk_en) begin
      if (take && word[`FWP_FW_IN_EN] && (word[6:4] == `FWP_IN_RSTART)) begin
        read_start <= 1'b1; // [RULE_04]
      end else if (mclr_rise) begin
        read_start <= 1'b0;
      end else if (take && word[`FWP_FW_IN_EN]) begin
        read_start <= 1'b0;
      end else if (head_s && !lock_active) begin
        read_start <= 1'b0; // [RULE_06]
      end
    end
  end

  // last accepted word, kept for software
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      last_fw_r <= '0;
    end else if (take) begin
      last_fw_r <= word;
    end
  end

  // lamp and motor follow the select flag
  assign printer_lamp  = printer_enable; // [RULE_07]
  assign printer_motor = printer_enable; // [RULE_07]

  // ****************************************
  // printer output loop
  // ****************************************
  fwp_pstate_e      pst_r;
  logic [31:0]      rdy_cnt_r;
  logic [CW-1:0]    out_reg_r;
  logic             push;
  logic             fifo_in_ready;
  logic [CW-1:0]    fifo_out_data;
  logic             fifo_out_valid;
  logic             ser_ready;
  logic             ser_done;
  fwp_div_t         div_r;

  // request only while the fifo can take the character
  assign output_word_request = (pst_r == FWP_P_REQ) & fifo_in_ready; // [RULE_08]
  assign push = clk_en & output_word_request & oack_rise; // [RULE_09]

  // loop sequencing; dropping the select flag ends it at once
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pst_r     <= FWP_P_OFF;
      rdy_cnt_r <= '0;
    end else if (clk_en) begin
      if (!printer_enable) begin
        pst_r <= FWP_P_OFF; // [RULE_15]
      end else begin
        case (pst_r)
          FWP_P_OFF: begin
            pst_r     <= FWP_P_WARM;
            rdy_cnt_r <= 32'(READY_CYC); // [RULE_19]
          end
          FWP_P_WARM: begin
            if (rdy_cnt_r <= 32'h0000_0001) begin
              pst_r <= FWP_P_REQ; // [RULE_08]
            end else begin
              rdy_cnt_r <= rdy_cnt_r - 1'b1;
            end
          end
          FWP_P_REQ: begin
            if (push) begin
              pst_r <= FWP_P_SEND; // [RULE_10]
            end
          end
          FWP_P_SEND: begin
            if (ser_done) begin
              pst_r <= FWP_P_REQ; // [RULE_13]
            end
          end
          default: begin
            pst_r <= FWP_P_OFF;
          end
        endcase
      end
    end
  end

  // output register: cleared while idle or after each character
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      out_reg_r <= '0;
    end else if (clk_en) begin
      if (push) begin
        out_reg_r <= data_s[CW-1:0]; // [RULE_10] [RULE_12]
      end else if (pst_r != FWP_P_SEND || ser_done) begin
        out_reg_r <= '0; // [RULE_08] [RULE_13]
      end
    end
  end

  // buffer decouples the host strobe from the slow serial frame
  fwp_fifo #(
    .W (CW),
    .D (`FWP_FIFO_D)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .clk_en    (clk_en),
    .in_data   (data_s[CW-1:0]),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (ser_ready)
  );

  fwp_serializer #(
    .W (CW)
  ) u_ser (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .clk_en   (clk_en),
    .bit_div  (div_r),
    .in_data  (fifo_out_data),
    .in_valid (fifo_out_valid),
    .in_ready (ser_ready),
    .txd      (printer_txd), // [RULE_11]
    .done     (ser_done)
  );

  // ****************************************
  // register port
  // ****************************************
  // bit time divisor, steers the serializer
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= `FWP_DIV_RST;
    end else if (clk_en && reg_wr && (reg_addr == `FWP_OFS_DIV)) begin
      div_r <= reg_wdata[15:0];
    end
  end

  // read data valid the cycle after the strobe; unmapped reads zero
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= '0;
      if (reg_rd) begin
        case (reg_addr)
          `FWP_OFS_DIV:   reg_rdata <= {16'h0000, div_r};
          `FWP_OFS_STAT:  reg_rdata <= {22'h000000, pst_r, read_start,
                                        reader_enable, keyboard_enable,
                                        perforator_enable, printer_enable,
                                        lock_active, func_req_r,
                                        output_word_request};
          `FWP_OFS_FWORD: reg_rdata <= {25'h0000000, last_fw_r};
          `FWP_OFS_CHAR:  reg_rdata <= {25'h0000000, out_reg_r};
          default:        reg_rdata <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic clr_any;
  assign clr_any = pclr_rise | mclr_rise;

  chk_out_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_01]
    take && !word[0] && !clr_any |=> printer_enable == $past(printer_enable)
      && perforator_enable == $past(perforator_enable))
    else $error("output enables changed without output enable bit");

  chk_out_sel: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_02]
    take && word[0] && !clr_any |=> printer_enable == $past(word[1])
      && perforator_enable == $past(word[2]))
    else $error("output device selection wrong");

  chk_in_hold: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_03]
    take && !word[3] && !mclr_rise |=> keyboard_enable == $past(keyboard_enable)
      && reader_enable == $past(reader_enable))
    else $error("input enables changed without input enable bit");

  chk_in_rstart: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_04]
    take && word[3] && word[6:4] == 3'h6 |=> reader_enable && read_start
      && !keyboard_enable)
    else $error("read start code not applied");

  chk_lockout_req: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_05]
    take |=> !function_request [*8])
    else $error("function request back during lockout");

  chk_head_block: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_06]
    clk_en && lock_active && read_start && !mclr_rise && !take |=> read_start)
    else $error("read start cleared during lockout");

  chk_motor_on: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_07]
    take && word[2:0] == 3'h3 && !clr_any |=> printer_motor && printer_lamp)
    else $error("printer word did not start motor");

  chk_load_char: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_10]
    push |=> pst_r == FWP_P_SEND && !output_word_request
      && out_reg_r == $past(data_s[CW-1:0]))
    else $error("output acknowledge not handled");

  chk_char_clear: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_13]
    clk_en && ser_done && printer_enable |=> out_reg_r == '0 && pst_r == FWP_P_REQ)
    else $error("register not cleared after character");

  chk_term_prn: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE_15]
    clk_en && clr_any |=> !printer_enable ##1 pst_r == FWP_P_OFF)
    else $error("printer not stopped by clear");
endmodule

// ---- sim/fwp_host.sv ----
/* host channel and printer model for the printer control bench.
   assumes one clock and ELEM clock cycles per serial element. */
`timescale 1ns/100ps
module fwp_host #(
  parameter int ELEM = 3
) (
  input  wire logic  sys_clk,
  input  wire logic  function_request,
  input  wire logic  output_word_request,
  input  wire logic  printer_txd,
  output logic       function_acknowledge,
  output logic       output_word_acknowledge,
  output logic [7:0] host_data
);
  logic [6:0] rx_char = 7'h00;
  int         rx_count = 0;
  int         frame_err = 0;
  int         stuck = 0;
  // idle host: no acknowledge raised
  initial begin
    function_acknowledge = 1'b0;
    output_word_acknowledge = 1'b0;
    host_data = 8'h00;
  end
  // ****************************************
  // host handshakes
  // ****************************************
  function automatic logic rq(input logic fn);
    return fn ? function_request : output_word_request;
  endfunction
  // data settle a cycle before the ack; released lines show the inverse,
  // so a design that latches late never sees the old word again
  task automatic hand(input logic [7:0] d, input logic fn);
    int n;
    n = 0;
    while (rq(fn) !== 1'b1 && n < 99) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    host_data <= d;
    @(posedge sys_clk);
    function_acknowledge <= fn;
    output_word_acknowledge <= ~fn;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rq(fn) !== 1'b0 && n < 199);
    function_acknowledge <= 1'b0;
    output_word_acknowledge <= 1'b0;
    host_data <= ~d;
    if (n >= 199) stuck++;
  endtask
  // ****************************************
  // printer receiver
  // ****************************************
  // sampling half a clock into each element on the falling clock keeps clear of txd updates
  always begin
    @(negedge printer_txd);
    @(negedge sys_clk);
    if (printer_txd !== 1'b0) frame_err++;
    for (int i = 0; i < 7; i++) begin
      repeat (ELEM) @(negedge sys_clk);
      rx_char[i] = printer_txd;
    end
    repeat (ELEM) @(negedge sys_clk);
    if (printer_txd !== 1'b1) frame_err++;
    rx_count++;
  end
endmodule

// ---- sim/function_word_printer_control_tb.sv ----
/* bench for the printer control: register tasks, function word table,
   printer loop and clears. assumes shortened lockout and ready counts. */
`timescale 1ns/100ps
module function_word_printer_control_tb;
  localparam int LOCK = 20;
  localparam int RDY  = 30;
  logic        sys_clk, nrst, clk_en, printer_clear, master_clear, head_raised;
  logic        reg_wr, reg_rd, function_acknowledge, output_word_acknowledge;
  logic        function_request, output_word_request, printer_enable, printer_lamp;
  logic        printer_motor, perforator_enable, keyboard_enable, reader_enable;
  logic        read_start, printer_txd;
  logic [7:0]  host_data;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [4:0]  ex;
  logic [7:0]  chars [3] = '{8'hC1, 8'hAA, 8'h7F};
  logic [6:0]  words [12] = '{7'h05, 7'h00, 7'h07, 7'h01, 7'h18, 7'h28,
                              7'h68, 7'h38, 7'h48, 7'h58, 7'h78, 7'h08};
  int          bad_count, total_checks, n, c;
  fwp_ctrl #(.LOCKOUT_CYC(LOCK), .READY_CYC(RDY)) dut_u (
    .sys_clk, .nrst, .clk_en, .function_acknowledge, .output_word_acknowledge,
    .host_data, .printer_clear, .master_clear, .head_raised, .function_request,
    .output_word_request, .printer_enable, .printer_lamp, .printer_motor,
    .perforator_enable, .keyboard_enable, .reader_enable, .read_start,
    .printer_txd, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  fwp_host #(.ELEM(3)) host_u (
    .sys_clk, .function_request, .output_word_request, .printer_txd,
    .function_acknowledge, .output_word_acknowledge, .host_data);
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      bad_count++;
      print_verdict();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask
  function automatic logic [4:0] en_now();
    return {perforator_enable, printer_enable, reader_enable, keyboard_enable, read_start};
  endfunction
  // expected enables {perf, printer, reader, keyboard, read start}
  function automatic logic [4:0] apply(input logic [4:0] s, input logic [6:0] w);
    logic [4:0] r;
    r = s;
    if (w[0]) r[4:3] = {w[2], w[1]};
    if (w[3]) begin
      case (w[6:4])
        3'h0: r[2:0] = 3'b000;
        3'h1: r[2:0] = 3'b010;
        3'h2: r[2:0] = 3'b100;
        3'h6: r[2:0] = 3'b101;
        default: r[0] = 1'b0;
      endcase
    end
    return r;
  endfunction
  // one function word; hr raises the head during the lockout
  task automatic fword(input logic [6:0] w, input logic hr);
    int k;
    k = 0;
    host_u.hand({1'b0, w}, 1'b1);
    tmo(host_u.stuck, 1);
    if (hr) head_raised <= 1'b1;
    ex = apply(ex, w);
    @(negedge sys_clk);
    chk({27'h0, en_now()}, {27'h0, ex});
    chk({31'h0, function_request}, 32'h0);
    while (function_request !== 1'b1 && k < LOCK + 8) begin
      if (hr && k < LOCK - 4) chk({31'h0, read_start}, 32'h1);
      @(negedge sys_clk);
      k++;
    end
    tmo(k, LOCK + 8);
    chk({31'h0, k >= LOCK - 3}, 32'h1);
    if (hr) begin
      k = 0;
      while (read_start !== 1'b0 && k < 8) begin
        @(negedge sys_clk);
        k++;
      end
      tmo(k, 8);
      ex[0] = 1'b0;
      @(posedge sys_clk);
      head_raised <= 1'b0;
    end
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    {sys_clk, nrst, printer_clear, master_clear, head_raised, reg_wr, reg_rd} = '0;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    bad_count = 0;
    total_checks = 0;
    ex = 5'h00;
    repeat (2) @(posedge sys_clk);
    chk({25'h0, function_request, output_word_request, en_now()}, 32'h40);
    chk({31'h0, printer_txd}, 32'h1);
    nrst <= 1'b1;
    rd(4'h0, 32'h0000_28B0);
    rd(4'h2, 32'h0);
    wr(4'h0, 32'h2);
    rd(4'h0, 32'h2);
    foreach (words[i]) fword(words[i], 1'b0);
    rd(4'h8, 32'h8);
    fword(7'h68, 1'b1);
    fword(7'h03, 1'b0);
    chk({30'h0, printer_lamp, printer_motor}, 32'h3);
    n = 0;
    while (output_word_request !== 1'b1 && n < RDY) begin
      @(negedge sys_clk);
      n++;
    end
    tmo(n, RDY);
    chk({31'h0, n + LOCK >= RDY - 3}, 32'h1);
    rd(4'hC, 32'h0);
    foreach (chars[i]) begin
      c = host_u.rx_count;
      host_u.hand(chars[i], 1'b0);
      tmo(host_u.stuck, 1);
      n = 0;
      while ((host_u.rx_count == c || output_word_request !== 1'b1) && n < 99) begin
        @(negedge sys_clk);
        n++;
      end
      tmo(n, 99);
      chk({25'h0, host_u.rx_char}, {25'h0, chars[i][6:0]});
      rd(4'hC, 32'h0);
    end
    chk(host_u.frame_err, 32'h0);
    // printer stopped by clear button, master clear and deselect word
    for (int m = 0; m < 3; m++) begin
      fword(7'h03, 1'b0);
      @(posedge sys_clk);
      printer_clear <= (m == 0);
      master_clear <= (m == 1);
      if (m == 2) fword(7'h01, 1'b0);
      n = 0;
      while (printer_enable !== 1'b0 && n < 9) begin
        @(negedge sys_clk);
        n++;
      end
      tmo(n, 9);
      // the loop state follows the select flag one edge later
      @(negedge sys_clk);
      chk({31'h0, output_word_request}, 32'h0);
      ex = (m == 1) ? 5'h00 : {ex[4], 1'b0, ex[2:0]};
      chk({27'h0, en_now()}, {27'h0, ex});
      @(posedge sys_clk);
      printer_clear <= 1'b0;
      master_clear <= 1'b0;
    end
    print_verdict();
  end
endmodule
